//--- inc/delay_counter_consts.svh
// constants for the delay counter channel and its interrupt steering
`ifndef DELAY_COUNTER_CONSTS_SVH
`define DELAY_COUNTER_CONSTS_SVH
`define MODE_TERM_PULSE   3'h0
`define MODE_ONE_SHOT     3'h1
`define MODE_SW_STROBE    3'h4
`define MODE_HW_STROBE    3'h5
`define ACC_LATCH         2'h0
`define ACC_LOW_ONLY      2'h1
`define ACC_HIGH_ONLY     2'h2
`define ACC_LOW_HIGH      2'h3
`define IRQ_SRC_TIMER     1'h0
`define IRQ_SRC_CONV      1'h1
`endif

//--- inc/delay_counter_pkg.sv
// types shared by the delay counter channel
package delay_counter_pkg;
    typedef logic [2:0] mode_code_t;
    typedef logic [1:0] access_code_t;
endpackage

//--- rtl/delay_counter.sv
// down-counter delay channel with four modes and interrupt request steering
`timescale 1ns/100ps
`include "delay_counter_consts.svh"

module delay_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic                          ref_clk,                // system clock
    input  wire logic                          rst_n,                  // async reset
    input  wire logic                          first_counter_clock_in, // counter clock pin
    input  wire logic                          counter_gate_pulse_in,  // gate pin
    input  wire logic                          cascade_timer_output,   // cascaded timer out pin
    input  wire logic                          external_conversion_trigger, // start pin
    input  wire logic                          sw_conv_start,          // software start pulse
    input  wire logic                          conv_done,              // converter end pulse
    input  wire logic                          mode_wr,                // mode write strobe
    input  wire delay_counter_pkg::mode_code_t operating_mode_field,   // mode code
    input  wire delay_counter_pkg::access_code_t byte_access_order_field, // byte order
    input  wire logic                          count_wr,               // count byte write
    input  wire logic [7:0]                    count_byte,             // count byte data
    input  wire logic                          irq_src_sel,            // interrupt source
    output logic                               counter_out,            // channel output
    output logic                               conv_start,             // start to converter
    output logic                               irq_req,                // interrupt request
    output logic [WIDTH-1:0]                   count_value             // current count
);
    // byte sequencer builds exactly two bytes, so no other width can be served
    if (WIDTH != 16) begin : g_width_check
        $error("delay_counter supports WIDTH 16 only");
    end

    logic                             clk_rise;
    logic                             gate_lvl;
    logic                             gate_rise;
    logic                             casc_rise;
    logic                             ext_rise;
    delay_counter_pkg::mode_code_t    mode_ff;
    delay_counter_pkg::access_code_t  acc_ff;
    logic                             hi_next_ff;
    logic [7:0]                       lo_hold_ff;
    logic [WIDTH-1:0]                 reload_ff;
    logic [WIDTH-1:0]                 cnt_ff;
    logic                             armed_ff;
    logic                             running_ff;
    logic                             out_ff;
    logic                             load_pulse;
    logic [WIDTH-1:0]                 load_val;
    logic                             src_ff;
    logic                             irq_ff;
    logic                             start_ff;

    edge_sync u_clk  (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(first_counter_clock_in),
                      .level_out(), .rise_out(clk_rise));
    edge_sync u_gate (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(counter_gate_pulse_in),
                      .level_out(gate_lvl), .rise_out(gate_rise));
    edge_sync u_casc (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(cascade_timer_output),
                      .level_out(), .rise_out(casc_rise));
    edge_sync u_ext  (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(external_conversion_trigger),
                      .level_out(), .rise_out(ext_rise));

    // ==========================================================
    // mode and byte sequencer
    // ==========================================================
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= `MODE_TERM_PULSE;
            acc_ff  <= `ACC_LOW_HIGH;
        end else if (mode_wr) begin
            mode_ff <= operating_mode_field;
            acc_ff  <= byte_access_order_field;
        end
    end

    // low byte first, high byte completes the load; mode write realigns
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_next_ff <= 1'h0;
            lo_hold_ff <= 8'h00;
        end else if (mode_wr) begin
            hi_next_ff <= 1'h0;
        end else if (count_wr && acc_ff == `ACC_LOW_HIGH) begin
            hi_next_ff <= ~hi_next_ff;
            if (!hi_next_ff) lo_hold_ff <= count_byte;
        end
    end

    always_comb begin
        load_pulse = 1'h0;
        load_val   = reload_ff;
        if (count_wr && !mode_wr) begin
            unique case (acc_ff)
                `ACC_LOW_ONLY: begin
                    load_pulse = 1'h1;
                    load_val   = {8'h00, count_byte};
                end
                `ACC_HIGH_ONLY: begin
                    load_pulse = 1'h1;
                    load_val   = {count_byte, 8'h00};
                end
                `ACC_LOW_HIGH: begin
                    load_pulse = hi_next_ff;
                    load_val   = {count_byte, lo_hold_ff};
                end
                `ACC_LATCH: begin
                    load_pulse = 1'h0;
                    load_val   = reload_ff;
                end
            endcase
        end
    end

    // ==========================================================
    // counter core
    // ==========================================================
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_ff  <= '0;
            cnt_ff     <= '0;
            armed_ff   <= 1'h0;
            running_ff <= 1'h0;
        end else if (load_pulse) begin
            reload_ff <= load_val;
            cnt_ff    <= load_val;
            armed_ff  <= 1'h1;
            // software modes run on load, gated ones wait for a gate rise
            running_ff <= (mode_ff == `MODE_TERM_PULSE) || (mode_ff == `MODE_SW_STROBE);
        end else if (armed_ff && gate_rise &&
                     (mode_ff == `MODE_ONE_SHOT || mode_ff == `MODE_HW_STROBE)) begin
            cnt_ff     <= reload_ff;
            running_ff <= 1'h1;
        end else if (running_ff && clk_rise) begin
            if (mode_ff == `MODE_TERM_PULSE && !gate_lvl) begin
                cnt_ff <= cnt_ff;
            end else if (cnt_ff == '0 || cnt_ff == WIDTH'(1)) begin
                cnt_ff     <= '0;
                running_ff <= 1'h0;
            end else begin
                cnt_ff <= cnt_ff - WIDTH'(1);
            end
        end
    end

    logic timeout;
    assign timeout = running_ff && clk_rise && (cnt_ff == '0 || cnt_ff == WIDTH'(1)) &&
                     !(mode_ff == `MODE_TERM_PULSE && !gate_lvl);

    // strobe low lasts until the next counter clock edge, a load, or in hardware strobe mode an armed gate rise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= 1'h1;
        end else begin
            unique case (mode_ff)
                `MODE_TERM_PULSE: begin
                    if (load_pulse) out_ff <= 1'h0;
                    else if (timeout) out_ff <= 1'h1;
                end
                `MODE_ONE_SHOT: begin
                    if (armed_ff && gate_rise && !load_pulse) out_ff <= 1'h0;
                    else if (timeout) out_ff <= 1'h1;
                end
                `MODE_SW_STROBE, `MODE_HW_STROBE: begin
                    if (load_pulse) out_ff <= 1'h1;
                    else if (armed_ff && gate_rise && mode_ff == `MODE_HW_STROBE)
                        out_ff <= 1'h1;
                    else if (timeout) out_ff <= 1'h0;
                    else if (clk_rise) out_ff <= 1'h1;
                end
                default: out_ff <= 1'h1;
            endcase
        end
    end

    // ==========================================================
    // conversion start and interrupt steering
    // ==========================================================
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_ff   <= `IRQ_SRC_TIMER;
            start_ff <= 1'h0;
            irq_ff   <= 1'h0;
        end else begin
            src_ff   <= irq_src_sel;
            start_ff <= ext_rise | sw_conv_start;
            irq_ff   <= (src_ff == `IRQ_SRC_CONV) ? conv_done : casc_rise;
        end
    end

    assign counter_out = out_ff;
    assign conv_start  = start_ff;
    assign irq_req     = irq_ff;
    assign count_value = cnt_ff;

    AST_LOAD_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (load_pulse && mode_ff == `MODE_TERM_PULSE && !mode_wr) |=> !counter_out)
        else $error("output not low after load");
    AST_GATE_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running_ff && mode_ff == `MODE_TERM_PULSE && !gate_lvl && !load_pulse)
        |=> $stable(cnt_ff))
        else $error("count moved with gate low");
    AST_TC_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode_ff == `MODE_TERM_PULSE && !mode_wr && timeout && !load_pulse) |=> counter_out)
        else $error("output not high at zero");
    AST_RETRIG: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (armed_ff && gate_rise && !load_pulse && !mode_wr && mode_ff == `MODE_ONE_SHOT)
        |=> (cnt_ff == reload_ff) && !counter_out)
        else $error("one-shot did not restart");
    AST_SHOT_RUN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode_ff == `MODE_ONE_SHOT && running_ff && clk_rise && !gate_rise && !load_pulse &&
         !mode_wr && cnt_ff > WIDTH'(1)) |=> cnt_ff == $past(cnt_ff) - WIDTH'(1))
        else $error("one-shot paused");
    AST_STROBE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode_ff == `MODE_SW_STROBE && !mode_wr && timeout && !load_pulse) |=> !counter_out)
        else $error("no strobe at timeout");
    AST_HW_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode_ff == `MODE_HW_STROBE && !mode_wr && armed_ff && gate_rise && !load_pulse)
        |=> counter_out && running_ff)
        else $error("hardware strobe did not start");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (src_ff == `IRQ_SRC_CONV && conv_done) |=> irq_req)
        else $error("missed conversion interrupt");
endmodule

//--- rtl/edge_sync.sv
// two-flop synchroniser with rising edge pulse
`timescale 1ns/100ps
module edge_sync (
    input  wire logic ref_clk,   // system clock
    input  wire logic rst_n,     // async reset, active low
    input  wire logic async_in,  // pin level from outside
    output logic      level_out, // synchronised level
    output logic      rise_out   // one-cycle pulse on rising edge
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'h0;
            sync_ff <= 1'h0;
            prev_ff <= 1'h0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level_out = sync_ff;
    assign rise_out  = sync_ff & ~prev_ff;
endmodule

//--- sim/delay_counter_tb.sv
// self-checking bench for the delay counter channel
`timescale 1ns/100ps
`include "delay_counter_consts.svh"
module delay_counter_tb;
    logic                           ref_clk = 1'b0, rst_n = 1'b0, run = 1'b0, gate_req = 1'b0;
    logic                           casc = 1'b0, ext_trig = 1'b0, sw_start = 1'b0, done = 1'b0;
    logic                           mode_wr = 1'b0, count_wr = 1'b0, irq_sel = 1'b0;
    delay_counter_pkg::mode_code_t  mode = 3'h0;
    delay_counter_pkg::access_code_t acc = 2'h3;
    logic [7:0]                     cbyte = 8'h00;
    logic                           cnt_clk, gate, counter_out, conv_start, irq_req;
    logic [15:0]                    count_value, v;
    int                             n_fail = 0, comparisons = 0;
    ext_sources src (.ref_clk(ref_clk), .run(run), .gate_req(gate_req), .cnt_clk(cnt_clk),
        .gate(gate));
    delay_counter dut (.ref_clk(ref_clk), .rst_n(rst_n), .first_counter_clock_in(cnt_clk),
        .counter_gate_pulse_in(gate), .cascade_timer_output(casc),
        .external_conversion_trigger(ext_trig), .sw_conv_start(sw_start), .conv_done(done),
        .mode_wr(mode_wr), .operating_mode_field(mode), .byte_access_order_field(acc),
        .count_wr(count_wr), .count_byte(cbyte), .irq_src_sel(irq_sel),
        .counter_out(counter_out), .conv_start(conv_start), .irq_req(irq_req),
        .count_value(count_value));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ======================================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic wait_out(input logic exp, input int lim);
        for (int i = 0; i < lim && counter_out !== exp; i++) cyc(1);
        chk({15'h0, exp}, {15'h0, counter_out});
    endtask
    // one-cycle pulses: look before each step so the first cycle is not missed
    task automatic wait_irq(input logic want_start, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (want_start ? (conv_start === 1'b1) : (irq_req === 1'b1)) seen = 1'b1;
            cyc(1);
        end
    endtask
    task automatic set_mode(input delay_counter_pkg::mode_code_t m);
        mode = m;
        mode_wr = 1'b1;
        cyc(1);
        mode_wr = 1'b0;
        cyc(1);
    endtask
    task automatic load(input logic [15:0] n);
        count_wr = 1'b1;
        cbyte = n[7:0];
        cyc(1);
        cbyte = n[15:8];
        cyc(1);
        count_wr = 1'b0;
        cyc(3);
    endtask
    task automatic stop_test;
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ======================================================
    // scenarios
    task automatic t_term_pulse;
        set_mode(`MODE_TERM_PULSE);
        load(16'h0005);
        chk(16'h0, {15'h0, counter_out});
        run = 1'b1;
        cyc(60);
        chk(16'h0005, count_value);
        gate_req = 1'b1;
        cyc(22);
        gate_req = 1'b0;
        cyc(10);
        v = count_value;
        cyc(50);
        chk(v, count_value);
        gate_req = 1'b1;
        wait_out(1'b1, 120);
        chk(16'h0, count_value);
        cyc(50);
        chk(16'h1, {15'h0, counter_out});
        run = 1'b0;
    endtask
    task automatic t_one_shot;
        gate_req = 1'b0;
        set_mode(`MODE_ONE_SHOT);
        load(16'h0004);
        run = 1'b1;
        gate_req = 1'b1;
        wait_out(1'b0, 10);
        gate_req = 1'b0;
        wait_out(1'b1, 100);
        cyc(40);
        chk(16'h1, {15'h0, counter_out});
        gate_req = 1'b1;
        wait_out(1'b0, 10);
        cyc(14);
        run = 1'b0;
        gate_req = 1'b0;
        cyc(8);
        gate_req = 1'b1;
        cyc(8);
        chk(16'h0004, count_value);
        chk(16'h0, {15'h0, counter_out});
    endtask
    task automatic t_sw_strobe;
        set_mode(`MODE_SW_STROBE);
        load(16'h0003);
        chk(16'h1, {15'h0, counter_out});
        run = 1'b1;
        wait_out(1'b0, 100);
        cyc(3);
        chk(16'h0, {15'h0, counter_out});
        wait_out(1'b1, 12);
        cyc(30);
        chk(16'h1, {15'h0, counter_out});
        run = 1'b0;
    endtask
    task automatic t_hw_strobe;
        gate_req = 1'b0;
        set_mode(`MODE_HW_STROBE);
        load(16'h0006);
        run = 1'b1;
        gate_req = 1'b1;
        wait_out(1'b1, 10);
        cyc(26);
        run = 1'b0;
        gate_req = 1'b0;
        cyc(8);
        gate_req = 1'b1;
        cyc(8);
        chk(16'h0006, count_value);
        run = 1'b1;
        wait_out(1'b0, 100);
        wait_out(1'b1, 12);
        gate_req = 1'b0;
        cyc(8);
        gate_req = 1'b1;
        wait_out(1'b0, 100);
        // park the clock so the strobe stays low until the gate rises
        run = 1'b0;
        gate_req = 1'b0;
        cyc(8);
        chk(16'h0, {15'h0, counter_out});
        gate_req = 1'b1;
        wait_out(1'b1, 6);
    endtask
    task automatic t_irq;
        logic seen;
        irq_sel = `IRQ_SRC_CONV;
        cyc(2);
        done = 1'b1;
        cyc(1);
        done = 1'b0;
        wait_irq(1'b0, seen);
        chk(16'h1, {15'h0, seen});
        irq_sel = `IRQ_SRC_TIMER;
        cyc(2);
        casc = 1'b1;
        wait_irq(1'b0, seen);
        casc = 1'b0;
        chk(16'h1, {15'h0, seen});
        sw_start = 1'b1;
        cyc(1);
        sw_start = 1'b0;
        wait_irq(1'b1, seen);
        chk(16'h1, {15'h0, seen});
        ext_trig = 1'b1;
        wait_irq(1'b1, seen);
        ext_trig = 1'b0;
        chk(16'h1, {15'h0, seen});
    endtask
    // ======================================================
    // main sequence and watchdog
    initial begin
        cyc(10);
        rst_n = 1'b1;
        cyc(2);
        t_term_pulse();
        t_one_shot();
        t_sw_strobe();
        t_hw_strobe();
        t_irq();
        stop_test();
    end
    initial begin
        // whole run needs about seven hundred cycles; allow ample margin
        #100000;
        n_fail++;
        stop_test();
    end
endmodule

//--- sim/ext_sources.sv
// gate and counter clock sources that sit outside the delay counter
`timescale 1ns/100ps
module ext_sources (
    input  wire logic ref_clk,  // bench clock, used only to pace the sources
    input  wire logic run,      // counter clock runs while high
    input  wire logic gate_req, // wanted gate level
    output logic      cnt_clk,  // counter clock pin
    output logic      gate      // gate pin
);
    int ph_ff;
    initial begin
        cnt_clk = 1'b0;
        gate    = 1'b0;
        ph_ff   = 0;
    end
    // clock parks low between bursts, so no stray edge is counted
    // pins move by non-blocking update on the rising edge: no race with the bench
    always @(posedge ref_clk) begin
        gate <= gate_req;
        if (!run) begin
            ph_ff   <= 0;
            cnt_clk <= 1'b0;
        end else begin
            ph_ff <= (ph_ff + 1) % 4;
            if (ph_ff == 3) cnt_clk <= ~cnt_clk;
        end
    end
endmodule
